// File: rtl/fgt_pkg.sv
// Constants for the fine gain trim register bank
package fgt_pkg;
    // Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
    localparam logic [11:0] IDX_CORE2_INPUT_A = 12'h362;
    localparam logic [11:0] IDX_CORE2_INPUT_B = 12'h363;
    localparam logic [11:0] IDX_CORE3_INPUT_C = 12'h364;
    localparam logic [11:0] IDX_CORE3_INPUT_D = 12'h365;
    localparam logic [11:0] IDX_CORE4         = 12'h366;
    localparam logic [11:0] IDX_CORE5         = 12'h367;
    localparam int          NUM_TRIMS         = 6;
    localparam int          REG_W             = 8;
    localparam int          TRIM_LSB          = 0;
    localparam int          TRIM_W            = 5;
    localparam logic [7:0]  RESV_RESET        = 8'h00;
    localparam int          ADDR_W            = 14;
    localparam int          FUSE_W            = NUM_TRIMS * TRIM_W;
    // Input pair selection codes for cores 2 and 3
    localparam logic [1:0]  SEL_PAIR_A        = 2'h0;
    localparam logic [1:0]  SEL_PAIR_B        = 2'h1;
    localparam logic [1:0]  SEL_PAIR_C        = 2'h2;
    localparam logic [1:0]  SEL_PAIR_D        = 2'h3;
endpackage : fgt_pkg

// File: rtl/fgt_trim_if.sv
// Carrier between the register store and the trim selector
`timescale 1ns/10ps
`default_nettype none
interface fgt_trim_if;
    logic [fgt_pkg::NUM_TRIMS*fgt_pkg::TRIM_W-1:0] trims;
    modport store (output trims);
    modport sel   (input trims);
endinterface : fgt_trim_if
`default_nettype wire

// File: rtl/fgt_trim_store.sv
// Trim register store with fuse-loaded defaults
`timescale 1ns/10ps
`default_nettype none
module fgt_trim_store (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        clk_en,
    // Fuse store
    input  wire logic [fgt_pkg::FUSE_W-1:0]  fuse_trims,
    input  wire logic                        fuse_valid,
    // Write port
    input  wire logic [fgt_pkg::NUM_TRIMS-1:0] wr_en,
    input  wire logic [fgt_pkg::TRIM_W-1:0]  wr_data,
    // Stored values
    fgt_trim_if.store                        trim_out,
    output logic                             loaded
);
    logic [fgt_pkg::FUSE_W-1:0] trim_q, trim_d;
    logic                       loaded_q, loaded_d;

    always_comb begin
        trim_d   = trim_q;
        loaded_d = loaded_q;
        // RULE7 fuse default load
        if (!loaded_q && fuse_valid) begin
            trim_d   = fuse_trims;
            loaded_d = 1'b1;
        end else begin
            for (int i = 0; i < fgt_pkg::NUM_TRIMS; i++) begin
                // RULE9 write updates trim
                if (wr_en[i]) begin
                    trim_d[i*fgt_pkg::TRIM_W +: fgt_pkg::TRIM_W] = wr_data;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_q   <= '0;
            loaded_q <= 1'b0;
        end else if (clk_en) begin
            trim_q   <= trim_d;
            loaded_q <= loaded_d;
        end
    end

    assign trim_out.trims = trim_q;
    assign loaded         = loaded_q;
endmodule : fgt_trim_store
`default_nettype wire

// File: rtl/fgt_trim_sel.sv
// Applies the stored trims to cores 2 and 3 by active input pair, and fixed trims to cores 4 and 5
`timescale 1ns/10ps
`default_nettype none
module fgt_trim_sel (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        clk_en,
    // Selection
    input  wire logic [1:0]                  core2_input_sel,
    input  wire logic [1:0]                  core3_input_sel,
    fgt_trim_if.sel                          trim_in,
    // Applied trims
    output logic [fgt_pkg::TRIM_W-1:0]       core2_gain,
    output logic [fgt_pkg::TRIM_W-1:0]       core3_gain,
    output logic [fgt_pkg::TRIM_W-1:0]       core4_gain,
    output logic [fgt_pkg::TRIM_W-1:0]       core5_gain
);
    localparam int W = fgt_pkg::TRIM_W;
    logic [W-1:0] c2_q, c2_d, c3_q, c3_d, c4_q, c4_d, c5_q, c5_d;

    always_comb begin
        // RULE8 core 2 on pair A
        c2_d = trim_in.trims[0*W +: W];
        // RULE1 core 2 on pair B
        if (core2_input_sel == fgt_pkg::SEL_PAIR_B) begin
            c2_d = trim_in.trims[1*W +: W];
        end
        // RULE2 core 3 on pair C
        c3_d = trim_in.trims[2*W +: W];
        // RULE3 core 3 on pair D
        if (core3_input_sel == fgt_pkg::SEL_PAIR_D) begin
            c3_d = trim_in.trims[3*W +: W];
        end
        // RULE4 core 4 fixed
        c4_d = trim_in.trims[4*W +: W];
        // RULE5 core 5 fixed
        c5_d = trim_in.trims[5*W +: W];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c2_q <= '0;
            c3_q <= '0;
            c4_q <= '0;
            c5_q <= '0;
        end else if (clk_en) begin
            c2_q <= c2_d;
            c3_q <= c3_d;
            c4_q <= c4_d;
            c5_q <= c5_d;
        end
    end

    assign core2_gain = c2_q;
    assign core3_gain = c3_q;
    assign core4_gain = c4_q;
    assign core5_gain = c5_q;
endmodule : fgt_trim_sel
`default_nettype wire

// File: rtl/fgt_bank.sv
// Fine gain trim register bank with APB slave
// Functional notes
// RULE1 - Core 2 uses the input B trim at index 0x363 bits 4:0 while sampling pair B.
// RULE2 - Core 3 uses the trim at index 0x364 while sampling pair C.
// RULE3 - Core 3 uses the trim at index 0x365 while sampling pair D.
// RULE4 - Core 4 always uses the trim at index 0x366.
// RULE5 - Core 5 always uses the trim at index 0x367.
// RULE6 - Software keeps bits 7:5 at zero on every write.
// RULE7 - Default trim contents come from the fuse store, not a constant.
// RULE8 - Core 2 uses the trim at index 0x362 while sampling pair A.
// RULE9 - A write updates the applied trim and a read returns the stored value.
`timescale 1ns/10ps
`default_nettype none
module fgt_bank (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        clk_en,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [fgt_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Fuse store
    input  wire logic [fgt_pkg::FUSE_W-1:0]  fuse_trims,
    input  wire logic                        fuse_valid,
    // Input selection from the mux control
    input  wire logic [1:0]                  core2_input_sel,
    input  wire logic [1:0]                  core3_input_sel,
    // Applied trims
    output logic [fgt_pkg::TRIM_W-1:0]       core2_gain,
    output logic [fgt_pkg::TRIM_W-1:0]       core3_gain,
    output logic [fgt_pkg::TRIM_W-1:0]       core4_gain,
    output logic [fgt_pkg::TRIM_W-1:0]       core5_gain
);
    localparam int W = fgt_pkg::TRIM_W;

    fgt_trim_if trim_bus ();

    logic [fgt_pkg::NUM_TRIMS-1:0] hit;
    logic [fgt_pkg::NUM_TRIMS-1:0] wr_en;
    logic                          mapped;
    logic                          loaded;
    logic                          access;
    logic [31:0]                   rdata_d, rdata_q;
    logic                          err_d, err_q;
    logic                          ready_d, ready_q;
    logic [11:0]                   idx;

    assign idx    = paddr[13:2];
    assign access = psel && penable;

    // Address decode
    always_comb begin
        hit = '0;
        if (paddr[1:0] != 2'h0) begin
            hit = '0;
        end else if (idx == fgt_pkg::IDX_CORE2_INPUT_A) begin
            hit[0] = 1'b1;
        end else if (idx == fgt_pkg::IDX_CORE2_INPUT_B) begin
            hit[1] = 1'b1;
        end else if (idx == fgt_pkg::IDX_CORE3_INPUT_C) begin
            hit[2] = 1'b1;
        end else if (idx == fgt_pkg::IDX_CORE3_INPUT_D) begin
            hit[3] = 1'b1;
        end else if (idx == fgt_pkg::IDX_CORE4) begin
            hit[4] = 1'b1;
        end else if (idx == fgt_pkg::IDX_CORE5) begin
            hit[5] = 1'b1;
        end
    end
    assign mapped = |hit;

    // Ready trails the fuse load by one cycle so a stalled read recaptures
    assign pready = ready_q;
    // RULE9 write strobe
    assign wr_en  = (access && pwrite && ready_q && clk_en) ? hit : '0;

    fgt_trim_store u_store (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_en     (clk_en),
        .fuse_trims (fuse_trims),
        .fuse_valid (fuse_valid),
        .wr_en      (wr_en),
        .wr_data    (pwdata[fgt_pkg::TRIM_LSB +: W]),
        .trim_out   (trim_bus),
        .loaded     (loaded)
    );

    fgt_trim_sel u_sel (
        .pclk            (pclk),
        .presetn         (presetn),
        .clk_en          (clk_en),
        .core2_input_sel (core2_input_sel),
        .core3_input_sel (core3_input_sel),
        .trim_in         (trim_bus),
        .core2_gain      (core2_gain),
        .core3_gain      (core3_gain),
        .core4_gain      (core4_gain),
        .core5_gain      (core5_gain)
    );

    // Read data captured in setup and while stalled, valid in access phase
    always_comb begin
        rdata_d = rdata_q;
        err_d   = err_q;
        ready_d = loaded;
        if (psel && (!penable || !ready_q)) begin
            rdata_d = '0;
            err_d   = !mapped;
            for (int i = 0; i < fgt_pkg::NUM_TRIMS; i++) begin
                // RULE9 read stored value
                if (hit[i]) begin
                    rdata_d[fgt_pkg::REG_W-1:0] = {fgt_pkg::RESV_RESET[7:5],
                                                   trim_bus.trims[i*W +: W]};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
            err_q   <= 1'b0;
            ready_q <= 1'b0;
        end else if (clk_en) begin
            rdata_q <= rdata_d;
            err_q   <= err_d;
            ready_q <= ready_d;
        end
    end

    // RULE6 upper bits ignored, read as zero
    assign prdata  = (access && !pwrite) ? rdata_q : '0;
    assign pslverr = access && err_q;
endmodule : fgt_bank
`default_nettype wire

// File: sim/fgt_bank_assertions.sv
// Port-level checks for the fine gain trim bank
`timescale 1ns/10ps
`default_nettype none
module fgt_bank_assertions (
    // Clock, reset and bus
    input wire logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [fgt_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata, prdata,
    // Fuse, selection and gains
    input wire logic [fgt_pkg::FUSE_W-1:0] fuse_trims,
    input wire logic [1:0]                 core2_input_sel, core3_input_sel,
    input wire logic [4:0]                 core2_gain, core3_gain, core4_gain, core5_gain
);
    wire logic hit = paddr[1:0] == 2'h0 && paddr[13:2] >= fgt_pkg::IDX_CORE2_INPUT_A
                     && paddr[13:2] <= fgt_pkg::IDX_CORE5;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wr(logic [11:0] idx);
        psel && penable && pwrite && pready && paddr == {idx, 2'h0};
    endsequence
    a_core2_pair_a: assert property (s_wr(fgt_pkg::IDX_CORE2_INPUT_A)
        ##1 core2_input_sel != fgt_pkg::SEL_PAIR_B |=> core2_gain == $past(pwdata[4:0], 2))
        else $error("core2 pair A trim");
    a_core2_pair_b: assert property (s_wr(fgt_pkg::IDX_CORE2_INPUT_B)
        ##1 core2_input_sel == fgt_pkg::SEL_PAIR_B |=> core2_gain == $past(pwdata[4:0], 2))
        else $error("core2 pair B trim");
    a_core3_pair_c: assert property (s_wr(fgt_pkg::IDX_CORE3_INPUT_C)
        ##1 core3_input_sel != fgt_pkg::SEL_PAIR_D |=> core3_gain == $past(pwdata[4:0], 2))
        else $error("core3 pair C trim");
    a_core3_pair_d: assert property (s_wr(fgt_pkg::IDX_CORE3_INPUT_D)
        ##1 core3_input_sel == fgt_pkg::SEL_PAIR_D |=> core3_gain == $past(pwdata[4:0], 2))
        else $error("core3 pair D trim");
    a_core4_trim: assert property (s_wr(fgt_pkg::IDX_CORE4)
        |-> ##2 core4_gain == $past(pwdata[4:0], 2)) else $error("core4 trim");
    a_core5_trim: assert property (s_wr(fgt_pkg::IDX_CORE5)
        |-> ##2 core5_gain == $past(pwdata[4:0], 2)) else $error("core5 trim");
    a_fuse_default: assert property ($rose(pready) |=> core4_gain == fuse_trims[24:20]
        && core5_gain == fuse_trims[29:25]) else $error("fuse default not applied");
    a_unmapped_err: assert property (psel && penable && pready
        |-> pslverr == !hit && (hit || prdata == 32'h0)) else $error("bad error response");
endmodule : fgt_bank_assertions
bind fgt_bank fgt_bank_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .fuse_trims(fuse_trims),
    .core2_input_sel(core2_input_sel), .core3_input_sel(core3_input_sel),
    .core2_gain(core2_gain), .core3_gain(core3_gain), .core4_gain(core4_gain),
    .core5_gain(core5_gain));
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the fine gain trim bank
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fuse_valid, err;
    logic        clk_en;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [29:0] fuse_trims;
    logic [1:0]  core2_input_sel, core3_input_sel;
    logic [4:0]  core2_gain, core3_gain, core4_gain, core5_gain, v;
    logic [4:0]  exp_q [6];
    logic [13:0] bad [3] = '{14'hd84, 14'hda0, 14'hd89};
    int          error_cnt, n_compared, i;
    fgt_bank uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fuse_trims(fuse_trims), .fuse_valid(fuse_valid),
        .core2_input_sel(core2_input_sel), .core3_input_sel(core3_input_sel),
        .core2_gain(core2_gain), .core3_gain(core3_gain), .core4_gain(core4_gain),
        .core5_gain(core5_gain));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, want);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 500);
        if (pready !== 1'b1) error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Core 2 picks slot 1 on pair B, core 3 slot 3 on pair D
    function automatic logic [31:0] pick(input logic hi, input int lo);
        return {27'h0, exp_q[hi ? lo + 1 : lo]};
    endfunction : pick
    task automatic gains;
        for (int s = 0; s < 4; s++) begin
            core2_input_sel <= 2'(s);
            core3_input_sel <= 2'(3 - s);
            repeat (2) @(posedge pclk);
            chk({27'h0, core2_gain}, pick(2'(s) == fgt_pkg::SEL_PAIR_B, 0));
            chk({27'h0, core3_gain}, pick(2'(3 - s) == fgt_pkg::SEL_PAIR_D, 2));
        end
        chk({27'h0, core4_gain}, {27'h0, exp_q[4]});
        chk({27'h0, core5_gain}, {27'h0, exp_q[5]});
    endtask : gains
    task end_of_test;
        if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    initial begin
        i = $urandom(75);
        {presetn, psel, penable, pwrite, fuse_valid} = 5'h0;
        clk_en = 1'b1;
        {paddr, pwdata, core2_input_sel, core3_input_sel} = '0;
        fuse_trims = 30'($urandom);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 6; i++) exp_q[i] = fuse_trims[5*i +: 5];
        fork
            apb(1'b0, 14'hd98, 32'h0);
            begin
                repeat (6) @(posedge pclk);
                fuse_valid <= 1'b1;
            end
        join
        chk(rd, {27'h0, exp_q[4]});
        for (i = 0; i < 6; i++) begin
            apb(1'b0, 14'hd88 + 14'(4 * i), 32'h0);
            chk(rd, {27'h0, exp_q[i]});
        end
        gains();
        for (int k = 0; k < 18; k++) begin
            i = k < 6 ? k : $urandom_range(5);
            v = k < 6 ? 5'h1f : 5'($urandom);
            core2_input_sel <= 2'(i);
            core3_input_sel <= 2'(i);
            apb(1'b1, 14'hd88 + 14'(4 * i), {27'h0, v});
            exp_q[i] = v;
            apb(1'b0, 14'hd88 + 14'(4 * i), 32'h0);
            chk(rd, {27'h0, v});
            if (k % 3 == 2) gains();
        end
        foreach (bad[j]) begin
            apb(1'b1, bad[j], 32'h15);
            chk({31'h0, err}, 32'h1);
            apb(1'b0, bad[j], 32'h0);
            chk({rd[31:1], err}, 32'h1);
        end
        // clock enable low holds applied trims
        core2_input_sel <= fgt_pkg::SEL_PAIR_A;
        core3_input_sel <= fgt_pkg::SEL_PAIR_C;
        repeat (2) @(posedge pclk);
        clk_en <= 1'b0;
        core2_input_sel <= fgt_pkg::SEL_PAIR_B;
        core3_input_sel <= fgt_pkg::SEL_PAIR_D;
        repeat (3) @(posedge pclk);
        chk({27'h0, core2_gain}, {27'h0, exp_q[0]});
        chk({27'h0, core3_gain}, {27'h0, exp_q[2]});
        clk_en <= 1'b1;
        gains();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
